//--- common/ufs_regs.vh
`ifndef UFS_REGS_VH
`define UFS_REGS_VH
// register indices
`define UFS_A_STAT 3'h0
`define UFS_A_CTRL 3'h1
`define UFS_A_MODE 3'h2
`define UFS_A_FCTL 3'h3
`define UFS_A_BAUD 3'h4
`define UFS_A_TXD 3'h5
`define UFS_A_RXD 3'h6
`define UFS_A_CNT 3'h7
// status flag positions
`define UFS_ER 7
`define UFS_TX_END_FLAG 6
`define UFS_TX_FIFO_EMPTY_FLAG 5
`define UFS_BRK 4
`define UFS_FER 3
`define UFS_PER 2
`define UFS_RDF 1
`define UFS_DR 0
`define UFS_STAT_RST 16'h0060
`define UFS_CLR_MASK 8'hF3
// control and mode fields
`define UFS_TE 5
`define UFS_RE 4
`define UFS_PE 5
`define UFS_ODD 4
`define UFS_STOP2 3
`define UFS_TTRG_LO 4
`define UFS_RTRG_LO 6
// sizes and timing
`define UFS_DEPTH 5'h10
`define UFS_TICKS_PER_ETU 16
`define UFS_DR_ETU 15
`define UFS_DR_TICKS (`UFS_DR_ETU * `UFS_TICKS_PER_ETU)
`define UFS_BAUD_RST 8'h00
`endif

//--- rtl/ufs_core.v
// Overview of operation
// - status register is 16 bits: error counts high, state flags low
// - flags ignore written 1; written 0 clears only after a read of 1
// - framing and parity error bits are read-only
// - status register starts at 0x0060 after reset or standby
// - stop bit sampled 0 sets the receive fault flag
// - parity mismatch with parity on sets the receive fault flag
// - disabling the receiver leaves the receive fault flag alone
// - faulty characters still enter the receive FIFO; reception goes on
// - with two stop bits only the first is checked
// - writing transmit data clears transmit end
// - transmit end set by reset, standby and clearing transmit enable
// - transmit end set when last bit sent and FIFO empty
// - FIFO-empty flag set when sending drops count below trigger
// - FIFO-empty flag clears on fill past trigger or read-then-zero
// - FIFO-empty flag forced to 1 by reset and standby
// - transmit FIFO holds 16 bytes; writes when full are dropped
// - count register upper byte shows transmit FIFO occupancy
// - break flag set on framing error with line staying at space
// - break flag clears on reset, standby or read-then-zero
// - receive-full flag set when stored bytes exceed receive trigger
// - data-ready set when few bytes wait and line idle 15 etu
// - framing and parity bits reflect the receive FIFO head entry
`timescale 1ns/10ps
`default_nettype none
`include "ufs_regs.vh"
module ufs_core (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    input wire standby,
    // register port
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // serial line
    input wire rxd,
    output wire txd
);
    localparam RS_IDLE = 3'd0;
    localparam RS_START = 3'd1;
    localparam RS_DATA = 3'd2;
    localparam RS_PAR = 3'd3;
    localparam RS_STOP = 3'd4;
    localparam RS_BRKC = 3'd5;
    localparam RS_MARK = 3'd6;
    localparam [15:0] STAT_RST = `UFS_STAT_RST;

    function [4:0] tx_trig;
        input [1:0] sel;
        begin
            if (sel == 2'h0)
                tx_trig = 5'h08;
            else if (sel == 2'h1)
                tx_trig = 5'h04;
            else if (sel == 2'h2)
                tx_trig = 5'h02;
            else
                tx_trig = 5'h01;
        end
    endfunction

    function [4:0] rx_trig;
        input [1:0] sel;
        begin
            if (sel == 2'h0)
                rx_trig = 5'h01;
            else if (sel == 2'h1)
                rx_trig = 5'h04;
            else if (sel == 2'h2)
                rx_trig = 5'h08;
            else
                rx_trig = 5'h0E;
        end
    endfunction

    // set wins over clear
    function upd;
        input f;
        input set;
        input clr;
        begin
            upd = set ? 1'b1 : (clr ? 1'b0 : f);
        end
    endfunction

    wire rst = sys_rst | standby;
    wire wr_stat = reg_wr && reg_addr == `UFS_A_STAT;
    wire wr_ctrl = reg_wr && reg_addr == `UFS_A_CTRL;
    wire wr_txd = reg_wr && reg_addr == `UFS_A_TXD;
    wire rd_stat = reg_rd && reg_addr == `UFS_A_STAT;
    wire rd_rxd = reg_rd && reg_addr == `UFS_A_RXD;

    // configuration registers
    reg [7:0] ctrl_q;
    reg [7:0] mode_q;
    reg [7:0] fctl_q;
    reg [7:0] baud_q;
    wire te = ctrl_q[`UFS_TE];
    wire re = ctrl_q[`UFS_RE];
    wire pe = mode_q[`UFS_PE];
    wire odd = mode_q[`UFS_ODD];
    wire stop2 = mode_q[`UFS_STOP2];
    wire [4:0] ttrg = tx_trig(fctl_q[`UFS_TTRG_LO+1:`UFS_TTRG_LO]);
    wire [4:0] rtrg = rx_trig(fctl_q[`UFS_RTRG_LO+1:`UFS_RTRG_LO]);
    wire te_fall = wr_ctrl && !reg_wdata[`UFS_TE] && te;

    // baud tick, 16 per bit
    reg [7:0] bcnt_q;
    wire tick = bcnt_q == baud_q;

    // transmit FIFO
    reg [7:0] tx_mem [0:15];
    reg [3:0] tx_wp_q;
    reg [3:0] tx_rp_q;
    reg [4:0] tx_cnt_q;
    wire tx_acc = wr_txd && tx_cnt_q != `UFS_DEPTH;
    reg ts_busy_q;
    reg [11:0] tx_shift_reg_q;
    reg [3:0] ts_bits_q;
    reg [3:0] ts_tk_q;
    wire tx_pop = !ts_busy_q && te && tx_cnt_q != 5'h00;
    wire ts_bit_end = ts_busy_q && tick && ts_tk_q == 4'hF;
    wire tx_done = ts_bit_end && ts_bits_q == 4'h1;
    wire [4:0] tx_cnt_d = tx_cnt_q + {4'h0, tx_acc} - {4'h0, tx_pop};
    wire [7:0] tx_head = tx_mem[tx_rp_q];
    assign txd = ts_busy_q ? tx_shift_reg_q[0] : 1'b1;

    // receive FIFO: data, framing bit, parity bit
    reg [9:0] rx_mem [0:15];
    reg [3:0] rx_wp_q;
    reg [3:0] rx_rp_q;
    reg [4:0] rx_cnt_q;
    reg [4:0] ferc_q;
    reg [4:0] perc_q;
    reg [2:0] rs_q;
    reg [3:0] rtk_q;
    reg [2:0] rbit_q;
    reg [7:0] rsh_q;
    reg rpar_q;
    reg rperr_q;
    wire rx_stop = tick && rs_q == RS_STOP && rtk_q == 4'hF;
    wire rx_fer = !rxd;
    wire rx_push = rx_stop && rx_cnt_q != `UFS_DEPTH;
    wire rx_pop = rd_rxd && rx_cnt_q != 5'h00;
    wire [4:0] rx_cnt_d = rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
    wire [9:0] rx_head = rx_cnt_q != 5'h00 ? rx_mem[rx_rp_q] : 10'h000;
    wire pop_fer = rx_pop && rx_head[9];
    wire pop_per = rx_pop && rx_head[8];

    // data-ready idle timer
    reg [7:0] dr_cnt_q;
    reg dr_run_q;
    wire dr_exp = dr_run_q && tick && rs_q == RS_IDLE
        && dr_cnt_q == (`UFS_DR_TICKS - 1);

    // status flags
    reg er_q;
    reg tx_end_flag_q;
    reg tx_fifo_empty_flag_q;
    reg brk_q;
    reg rdf_q;
    reg dr_q;
    reg [7:0] arm_q;
    reg brk_set;
    wire [7:0] clr = {8{wr_stat}} & ~reg_wdata[7:0] & arm_q;
    wire [3:0] ferc_v = ferc_q[4] ? 4'hF : ferc_q[3:0];
    wire [3:0] perc_v = perc_q[4] ? 4'hF : perc_q[3:0];
    wire [15:0] stat = {perc_v, ferc_v, er_q, tx_end_flag_q, tx_fifo_empty_flag_q, brk_q,
        rx_head[9], rx_head[8], rdf_q, dr_q};

    // configuration and register reads
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_q <= 8'h00;
            mode_q <= 8'h00;
            fctl_q <= 8'h00;
            baud_q <= `UFS_BAUD_RST;
            reg_rdata <= 16'h0000;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata[7:0] & 8'h30;
            else if (reg_wr && reg_addr == `UFS_A_MODE)
                mode_q <= reg_wdata[7:0] & 8'h38;
            else if (reg_wr && reg_addr == `UFS_A_FCTL)
                fctl_q <= reg_wdata[7:0] & 8'hF0;
            else if (reg_wr && reg_addr == `UFS_A_BAUD)
                baud_q <= reg_wdata[7:0];
            if (!reg_rd)
                reg_rdata <= 16'h0000;
            else if (reg_addr == `UFS_A_STAT)
                reg_rdata <= stat;
            else if (reg_addr == `UFS_A_CTRL)
                reg_rdata <= {8'h00, ctrl_q};
            else if (reg_addr == `UFS_A_MODE)
                reg_rdata <= {8'h00, mode_q};
            else if (reg_addr == `UFS_A_FCTL)
                reg_rdata <= {8'h00, fctl_q};
            else if (reg_addr == `UFS_A_BAUD)
                reg_rdata <= {8'h00, baud_q};
            else if (reg_addr == `UFS_A_RXD)
                reg_rdata <= {8'h00, rx_head[7:0]};
            else if (reg_addr == `UFS_A_CNT)
                reg_rdata <= {3'h0, tx_cnt_q, 3'h0, rx_cnt_q};
            else
                reg_rdata <= 16'h0000;
        end
    end

    // baud divider
    always @(posedge clk_sys)
    begin
        if (rst || tick)
            bcnt_q <= 8'h00;
        else
            bcnt_q <= bcnt_q + 8'h01;
    end

    // transmit FIFO and shifter
    always @(posedge clk_sys)
    begin
        if (tx_acc)
            tx_mem[tx_wp_q] <= reg_wdata[7:0];
    end

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            tx_wp_q <= 4'h0;
            tx_rp_q <= 4'h0;
            tx_cnt_q <= 5'h00;
            ts_busy_q <= 1'b0;
            tx_shift_reg_q <= 12'hFFF;
            ts_bits_q <= 4'h0;
            ts_tk_q <= 4'h0;
        end
        else
        begin
            tx_cnt_q <= tx_cnt_d;
            if (tx_acc)
                tx_wp_q <= tx_wp_q + 4'h1;
            if (tx_pop)
            begin
                tx_rp_q <= tx_rp_q + 4'h1;
                ts_busy_q <= 1'b1;
                ts_tk_q <= 4'h0;
                tx_shift_reg_q <= {2'b11,
                    pe ? (^tx_head) ^ odd : 1'b1, tx_head, 1'b0};
                ts_bits_q <= 4'hA + {3'h0, pe} + {3'h0, stop2};
            end
            else if (ts_busy_q && tick)
            begin
                ts_tk_q <= ts_tk_q + 4'h1;
                if (ts_bit_end)
                begin
                    tx_shift_reg_q <= {1'b1, tx_shift_reg_q[11:1]};
                    ts_bits_q <= ts_bits_q - 4'h1;
                    if (tx_done)
                        ts_busy_q <= 1'b0;
                end
            end
        end
    end

    // receive FIFO write
    always @(posedge clk_sys)
    begin
        if (rx_push)
            rx_mem[rx_wp_q] <= {rx_fer, rperr_q, rsh_q};
    end

    // receiver
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            rs_q <= RS_IDLE;
            rtk_q <= 4'h0;
            rbit_q <= 3'h0;
            rsh_q <= 8'h00;
            rpar_q <= 1'b0;
            rperr_q <= 1'b0;
            rx_wp_q <= 4'h0;
            rx_rp_q <= 4'h0;
            rx_cnt_q <= 5'h00;
            ferc_q <= 5'h00;
            perc_q <= 5'h00;
            brk_set <= 1'b0;
        end
        else
        begin
            rx_cnt_q <= rx_cnt_d;
            brk_set <= 1'b0;
            if (rx_push)
                rx_wp_q <= rx_wp_q + 4'h1;
            if (rx_pop)
                rx_rp_q <= rx_rp_q + 4'h1;
            ferc_q <= ferc_q + {4'h0, rx_push && rx_fer}
                - {4'h0, pop_fer};
            perc_q <= perc_q + {4'h0, rx_push && rperr_q}
                - {4'h0, pop_per};
            if (tick && rs_q != RS_IDLE && rs_q != RS_MARK)
                rtk_q <= rtk_q + 4'h1;
            case (rs_q)
                RS_IDLE:
                    if (re && !rxd)
                    begin
                        rs_q <= RS_START;
                        rtk_q <= 4'h0;
                    end
                RS_START:
                    if (tick && rtk_q == 4'h7)
                    begin
                        rs_q <= rxd ? RS_IDLE : RS_DATA;
                        rtk_q <= 4'h0;
                        rbit_q <= 3'h0;
                        rpar_q <= 1'b0;
                        rperr_q <= 1'b0;
                    end
                RS_DATA:
                    if (tick && rtk_q == 4'hF)
                    begin
                        rsh_q <= {rxd, rsh_q[7:1]};
                        rpar_q <= rpar_q ^ rxd;
                        rbit_q <= rbit_q + 3'h1;
                        if (rbit_q == 3'h7)
                            rs_q <= pe ? RS_PAR : RS_STOP;
                    end
                RS_PAR:
                    if (tick && rtk_q == 4'hF)
                    begin
                        rperr_q <= rpar_q ^ rxd ^ odd;
                        rs_q <= RS_STOP;
                    end
                RS_STOP:
                    if (rx_stop)
                        rs_q <= rx_fer ? RS_BRKC : RS_IDLE;
                RS_BRKC:
                    if (tick && rtk_q == 4'hF)
                    begin
                        brk_set <= !rxd;
                        rs_q <= rxd ? RS_IDLE : RS_MARK;
                    end
                RS_MARK:
                    if (rxd)
                        rs_q <= RS_IDLE;
                default:
                    rs_q <= RS_IDLE;
            endcase
        end
    end

    // data-ready timer, restarted at each stop bit
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            dr_cnt_q <= 8'h00;
            dr_run_q <= 1'b0;
        end
        else if (rx_stop)
        begin
            dr_cnt_q <= 8'h00;
            dr_run_q <= 1'b1;
        end
        else if (rs_q == RS_START || dr_exp)
            dr_run_q <= 1'b0;
        else if (dr_run_q && tick && rs_q == RS_IDLE)
            dr_cnt_q <= dr_cnt_q + 8'h01;
    end

    // status flags
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            er_q <= STAT_RST[`UFS_ER];
            tx_end_flag_q <= STAT_RST[`UFS_TX_END_FLAG];
            tx_fifo_empty_flag_q <= STAT_RST[`UFS_TX_FIFO_EMPTY_FLAG];
            brk_q <= STAT_RST[`UFS_BRK];
            rdf_q <= STAT_RST[`UFS_RDF];
            dr_q <= STAT_RST[`UFS_DR];
            arm_q <= 8'h00;
        end
        else
        begin
            // receiver enable plays no part here
            er_q <= upd(er_q, rx_stop && (rx_fer || rperr_q),
                clr[`UFS_ER]);
            tx_end_flag_q <= te_fall || tx_done && tx_cnt_q == 5'h00 ? 1'b1
                : (tx_acc || clr[`UFS_TX_END_FLAG] ? 1'b0 : tx_end_flag_q);
            tx_fifo_empty_flag_q <= upd(tx_fifo_empty_flag_q, tx_pop && tx_cnt_d < ttrg,
                tx_acc && tx_cnt_d > ttrg || clr[`UFS_TX_FIFO_EMPTY_FLAG]);
            brk_q <= upd(brk_q, brk_set, clr[`UFS_BRK]);
            rdf_q <= upd(rdf_q, rx_push && rx_cnt_d > rtrg,
                clr[`UFS_RDF] && !(rx_cnt_q > rtrg));
            dr_q <= upd(dr_q, dr_exp && rx_cnt_q != 5'h00
                && rx_cnt_q < rtrg, clr[`UFS_DR]);
            if (rd_stat)
                arm_q <= stat[7:0] & `UFS_CLR_MASK;
            else
                arm_q <= arm_q & stat[7:0] & ~clr;
        end
    end
endmodule // ufs_core
`default_nettype wire

//--- test/ufs_core_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "ufs_regs.vh"
module ufs_core_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic standby,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // serial line
    input wire logic rxd,
    input wire logic txd
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_rdata_idle: assert property
        (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not idle");
    a_reset_status: assert property
        ($past(standby) && !standby && reg_rd && reg_addr == `UFS_A_STAT
        |=> reg_rdata == `UFS_STAT_RST)
        else $error("status wrong after standby");
    a_standby_idle: assert property
        (standby |=> reg_rdata == 16'h0000 && txd)
        else $error("outputs not idle in standby");
    a_txd_reset: assert property
        ($past(sys_rst) |-> txd)
        else $error("line not idle after reset");
    a_bit_hold: assert property
        (disable iff (sys_rst || standby)
        $changed(txd) |=> !$changed(txd) [*8])
        else $error("line bit too short");
    a_cnt_bound: assert property
        (reg_rd && reg_addr == `UFS_A_CNT
        |=> reg_rdata[12:8] <= 5'h10 && reg_rdata[4:0] <= 5'h10)
        else $error("fifo count above depth");
    a_tx_end_flag_clear: assert property
        (reg_wr && reg_addr == `UFS_A_TXD ##2 reg_rd && reg_addr == `UFS_A_STAT
        |=> !reg_rdata[`UFS_TX_END_FLAG])
        else $error("transmit end not cleared");
    a_clear_unread: assert property
        ($past(sys_rst) && reg_wr && reg_addr == `UFS_A_STAT
        && reg_wdata == 16'h0000 ##2 reg_rd && reg_addr == `UFS_A_STAT
        |=> reg_rdata[6:5] == 2'b11)
        else $error("unread flag cleared");
endmodule // ufs_core_props
bind ufs_core ufs_core_props u_props (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .standby(standby),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rxd(rxd),
    .txd(txd)
);
`default_nettype wire

//--- test/ufs_remote.sv
`timescale 1ns/10ps
`default_nettype none
module ufs_remote (
    // clock
    input wire logic clk_sys,
    // serial line
    input wire logic txd,
    output var logic rxd
);
    logic [7:0] rx_byte;
    int rx_cnt;
    initial
    begin
        rxd = 1'b1;
        rx_cnt = 0;
        rx_byte = 8'h00;
    end
    // one bit time, sixteen one-cycle ticks
    task automatic bit_out(input logic v);
        rxd <= v;
        repeat (16) @(posedge clk_sys);
    endtask
    // start, data lsb first, even parity (odd if flip), stop, space hold
    task automatic send(input logic [7:0] b, input logic par,
        input logic flip, input logic stop, input int hold);
        int n;
        @(posedge clk_sys);
        bit_out(1'b0);
        for (n = 0; n < 8; n++)
            bit_out(b[n]);
        if (par)
            bit_out(^b ^ flip);
        bit_out(stop);
        repeat (hold) bit_out(1'b0);
        repeat (2) bit_out(1'b1);
    endtask
    // collects characters sent by the device
    always
    begin
        @(negedge txd);
        repeat (8) @(posedge clk_sys);
        for (int j = 0; j < 8; j++)
        begin
            repeat (16) @(posedge clk_sys);
            rx_byte[j] = txd;
        end
        repeat (16) @(posedge clk_sys);
        rx_cnt++;
    end
endmodule // ufs_remote
`default_nettype wire

//--- test/test_ufs_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "ufs_regs.vh"
module test_ufs_core;
    logic clk_sys;
    logic sys_rst;
    logic standby;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    wire [15:0] reg_rdata;
    wire rxd;
    wire txd;
    logic [15:0] rv;
    int err_total;
    int samples_checked;
    int cyc;
    int i;

    ufs_core dut (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .standby(standby),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .rxd(rxd),
        .txd(txd)
    );
    ufs_remote rem (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

    always #2.5 clk_sys = ~clk_sys;

    task automatic final_report();
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp,
        input logic [15:0] got, input logic [15:0] msk);
        samples_checked++;
        if ((got & msk) !== (exp & msk))
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp & msk, got & msk);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [15:0] exp,
        input logic [15:0] msk, input string nm);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
        chk(nm, exp, rv, msk);
    endtask

    task automatic wait_rx(input int n);
        int k;
        for (k = 0; k < 4000 && rem.rx_cnt < n; k++)
            @(posedge clk_sys);
    endtask

    initial
    begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        standby = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (4) @(posedge clk_sys);
        // zero written to never-read flags on the first edge
        sys_rst <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= `UFS_A_STAT;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        rchk(`UFS_A_STAT, 16'h0060, 16'hFFFF, "status reset");
        // one character out
        wr(`UFS_A_FCTL, 16'h0030);
        wr(`UFS_A_CTRL, 16'h0030);
        wr(`UFS_A_TXD, 16'h00A5);
        rchk(`UFS_A_STAT, 16'h0000, 16'h0040, "tx_end_flag on write");
        wait_rx(1);
        chk("line byte", 16'h00A5, {8'h00, rem.rx_byte}, 16'h00FF);
        repeat (20) @(posedge clk_sys);
        rchk(`UFS_A_STAT, 16'h0060, 16'h0060, "tx idle");
        // fill past full with the transmitter off, then drain
        wr(`UFS_A_CTRL, 16'h0010);
        wr(`UFS_A_FCTL, 16'h0000);
        for (i = 0; i < 17; i++)
            wr(`UFS_A_TXD, i[15:0]);
        rchk(`UFS_A_CNT, 16'h1000, 16'h1F00, "tx count");
        rchk(`UFS_A_STAT, 16'h0000, 16'h0060, "full flags");
        wr(`UFS_A_CTRL, 16'h0030);
        wait_rx(17);
        chk("last byte", 16'h000F, {8'h00, rem.rx_byte}, 16'h00FF);
        chk("byte total", 16'h0011, rem.rx_cnt[15:0], 16'hFFFF);
        repeat (20) @(posedge clk_sys);
        rchk(`UFS_A_STAT, 16'h0060, 16'h0060, "drained");
        wr(`UFS_A_STAT, 16'h0000);
        rchk(`UFS_A_STAT, 16'h0000, 16'h0060, "sw clear");
        wr(`UFS_A_STAT, 16'hFFFF);
        rchk(`UFS_A_STAT, 16'h0000, 16'h00FF, "ones ignored");
        wr(`UFS_A_CTRL, 16'h0010);
        rchk(`UFS_A_STAT, 16'h0040, 16'h0060, "tx_end_flag on off");
        // clean character, then a bad stop bit
        rem.send(8'h3C, 1'b0, 1'b0, 1'b1, 0);
        rem.send(8'h55, 1'b0, 1'b0, 1'b0, 0);
        rchk(`UFS_A_STAT, 16'h01C2, 16'hFFFF, "two in");
        rchk(`UFS_A_RXD, 16'h003C, 16'h00FF, "first char");
        rchk(`UFS_A_STAT, 16'h01CA, 16'hFFFF, "bad head");
        wr(`UFS_A_STAT, 16'h0000);
        rchk(`UFS_A_STAT, 16'h0108, 16'hFFFF, "after clear");
        rchk(`UFS_A_RXD, 16'h0055, 16'h00FF, "bad char kept");
        // parity fault, then receiver off
        wr(`UFS_A_MODE, 16'h0020);
        rem.send(8'h01, 1'b1, 1'b1, 1'b1, 0);
        rchk(`UFS_A_STAT, 16'h1084, 16'hFF8C, "parity");
        wr(`UFS_A_CTRL, 16'h0000);
        rchk(`UFS_A_STAT, 16'h0080, 16'h0080, "fault kept");
        // framing error with the line held at space
        wr(`UFS_A_CTRL, 16'h0010);
        wr(`UFS_A_MODE, 16'h0000);
        rem.send(8'h00, 1'b0, 1'b0, 1'b0, 2);
        rchk(`UFS_A_STAT, 16'h0010, 16'h0010, "break");
        // standby acts as reset
        @(posedge clk_sys);
        standby <= 1'b1;
        repeat (2) @(posedge clk_sys);
        standby <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= `UFS_A_STAT;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("standby", 16'h0060, reg_rdata, 16'hFFFF);
        // odd parity, two stop bits, then idle timeout
        wr(`UFS_A_FCTL, 16'h0040);
        wr(`UFS_A_MODE, 16'h0038);
        wr(`UFS_A_CTRL, 16'h0010);
        rem.send(8'h03, 1'b1, 1'b1, 1'b1, 0);
        rchk(`UFS_A_STAT, 16'h0060, 16'hFFFF, "odd clean");
        repeat (240) @(posedge clk_sys);
        rchk(`UFS_A_STAT, 16'h0061, 16'hFFFF, "data ready");
        rchk(`UFS_A_RXD, 16'h0003, 16'h00FF, "odd char");
        final_report();
    end
endmodule // test_ufs_core
`default_nettype wire
